// file: rtl/sdp_top.sv
// Notes on behaviour
// - valid configuration index: read current, write new
// - unsupported sensor type: information reads all zero
// - max range fixed, independent of dynamic range
// - max range 16-bit, bytes 4-5, rounded up
// - bytes 6-7 hold resolution bit count
// - byte 0 echoes requested sensor type
// - type byte bit 4 set for non-wakeup
// - byte 1 holds unique driver identifier
// - byte 2 holds driver version
// - bytes 4-5 report maximum range, SI units
// - bytes 10-11: reserved FIFO over packet size
// - shared FIFO may report zero reserved
// - bytes 12-13: whole FIFO over packet size
// - byte 14: packet length including type byte
// - index: bits 0-4 id, 5 wakeup, 6 configuration
// - information indices read only, writes ignored
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`default_nettype none
module sdp_top #(
  parameter int ADDR_W = 8,
  parameter logic [31:0] SUPPORTED_MASK = 32'h8000_001F,
  parameter logic [7:0] DRIVER_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] DRIVER_VER = 8'h01, // arbitrary value
  parameter logic [7:0] POWER = 8'h00,
  parameter int MAX_RANGE_MILLI = 156930,
  parameter logic [15:0] RES_BITS = 16'h000C,
  parameter logic [15:0] MAX_RATE = 16'h0000,
  parameter logic [7:0] MIN_RATE = 8'h00,
  parameter bit SHARED_FIFO = 1'b1,
  parameter int FIFO_RSV_BYTES = 0,
  parameter int FIFO_TOTAL_BYTES = 2048,
  parameter int EVENT_SIZE = 7
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----------------------------------------------------------------
  // fixed information values
  // ----------------------------------------------------------------
  // ceiling of the milli-unit range keeps fractional ranges from shrinking
  localparam int MAX_RANGE_INT = (MAX_RANGE_MILLI + 999) / 1000;
  localparam logic [15:0] MAX_RANGE_W = 16'(MAX_RANGE_INT);
  localparam logic [15:0] FIFO_RSV_W =
    SHARED_FIFO ? 16'h0000 : 16'(FIFO_RSV_BYTES / EVENT_SIZE);
  localparam logic [15:0] FIFO_MAX_W = 16'(FIFO_TOTAL_BYTES / EVENT_SIZE);
  localparam logic [7:0] EVENT_SIZE_W = 8'(EVENT_SIZE);

  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [6:0] idx;
    logic ignored;
    logic [63:0] wbuf;
    logic [127:0] rbuf;
    logic [63:0][63:0] cfg;
  } sdp_state_t;

  sdp_state_t s_q;
  sdp_state_t s_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // sensor ids 0 and 26..30 are holes in both halves of the index space
  function automatic logic sdp_id_valid(input logic [4:0] id);
    sdp_id_valid = (id != 5'h00) && !((id >= sdp_pkg::RSV_ID_LO) &&
                                      (id <= sdp_pkg::RSV_ID_HI));
  endfunction

  // information structure, byte 0 in the low bits
  function automatic logic [127:0] sdp_info(input logic [6:0] idx);
    logic [7:0] type_b;
    type_b = {1'b0, idx};
    sdp_info = '0;
    if (sdp_id_valid(idx[4:0]) && SUPPORTED_MASK[idx[4:0]])
    begin
      if (!idx[sdp_pkg::IDX_WAKE_BIT])
      begin
        type_b = type_b | sdp_pkg::NONWAKE_TYPE_BIT;
      end
      sdp_info[7:0] = type_b;
      sdp_info[15:8] = DRIVER_ID;
      sdp_info[23:16] = DRIVER_VER;
      sdp_info[31:24] = POWER;
      sdp_info[47:32] = MAX_RANGE_W;
      sdp_info[63:48] = RES_BITS;
      sdp_info[79:64] = MAX_RATE;
      sdp_info[95:80] = FIFO_RSV_W;
      sdp_info[111:96] = FIFO_MAX_W;
      sdp_info[119:112] = EVENT_SIZE_W;
      sdp_info[127:120] = MIN_RATE;
    end
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic do_wr;
  logic do_rd;
  logic [ADDR_W-1:0] wa;
  logic [ADDR_W-1:0] ra;
  logic [31:0] wmask;
  logic [31:0] cur_word;
  logic [4:0] sid;
  logic [5:0] slot;

  // a write is carried out once address and data are both held
  always_comb
  begin
    s_d = s_q;
    wmask = '0;
    cur_word = '0;
    sid = '0;
    slot = '0;
    wa = s_q.aw_addr;
    ra = s_axi_araddr;
    // address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
      wa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    do_wr = s_d.aw_held && s_d.w_held && !s_q.bvalid;
    for (int i = 0; i < 4; i++)
    begin
      wmask[i*8 +: 8] = {8{s_d.w_strb[i]}};
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end
    if (do_wr)
    begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = sdp_pkg::RESP_OKAY;
      case (wa[7:0])
        sdp_pkg::OFS_CTRL:
        begin
          // only the low byte carries the index and the direction
          if (s_d.w_strb[0])
          begin
            sid = s_d.w_data[4:0];
            slot = {s_d.w_data[sdp_pkg::IDX_WAKE_BIT], sid};
            s_d.idx = s_d.w_data[6:0];
            s_d.ignored = 1'b0;
            if (!s_d.w_data[sdp_pkg::CTRL_WR_BIT])
            begin
              // read request: load the read buffer
              if (!s_d.w_data[sdp_pkg::IDX_CFG_BIT])
              begin
                s_d.rbuf = sdp_info(s_d.w_data[6:0]);
              end
              else if (sdp_id_valid(sid))
              begin
                s_d.rbuf = {64'h0, s_q.cfg[slot]};
              end
              else
              begin
                s_d.rbuf = '0;
              end
            end
            else if (s_d.w_data[sdp_pkg::IDX_CFG_BIT] && sdp_id_valid(sid))
            begin
              s_d.cfg[slot] = s_q.wbuf;
            end
            else
            begin
              // information and reserved indices change only the stored index and the ignored flag
              s_d.ignored = 1'b1;
            end
          end
        end
        sdp_pkg::OFS_WBUF0:
        begin
          s_d.wbuf[31:0] = (s_q.wbuf[31:0] & ~wmask) | (s_d.w_data & wmask);
        end
        sdp_pkg::OFS_WBUF1:
        begin
          s_d.wbuf[63:32] = (s_q.wbuf[63:32] & ~wmask) | (s_d.w_data & wmask);
        end
        sdp_pkg::OFS_STATUS, 8'h10, 8'h14, 8'h18, sdp_pkg::OFS_RBUF3:
        begin
          s_d.bresp = sdp_pkg::RESP_OKAY; // read-only words drop the data
        end
        default:
        begin
          s_d.bresp = sdp_pkg::RESP_SLVERR;
        end
      endcase
    end
    // read channel: one cycle to the answer, held until rready
    if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
    do_rd = s_axi_arvalid && s_axi_arready;
    if (do_rd)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = sdp_pkg::RESP_OKAY;
      case (ra[7:0])
        sdp_pkg::OFS_CTRL:
        begin
          cur_word = {25'h0, s_q.idx};
        end
        sdp_pkg::OFS_WBUF0:
        begin
          cur_word = s_q.wbuf[31:0];
        end
        sdp_pkg::OFS_WBUF1:
        begin
          cur_word = s_q.wbuf[63:32];
        end
        sdp_pkg::OFS_STATUS:
        begin
          cur_word = {23'h0, s_q.ignored, 1'b0, s_q.idx};
        end
        sdp_pkg::OFS_RBUF0, 8'h14, 8'h18, sdp_pkg::OFS_RBUF3:
        begin
          cur_word = s_q.rbuf[ra[3:2]*32 +: 32];
        end
        default:
        begin
          s_d.rresp = sdp_pkg::RESP_SLVERR;
        end
      endcase
      s_d.rdata = cur_word;
    end
  end

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  // a held item or a pending response blocks its channel until the response is accepted
  assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_held && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // configuration memory clears on reset so first reads are defined
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      for (int i = 0; i < 64; i++)
      begin
        s_q.cfg[i] <= sdp_pkg::RST_CFG;
      end
      s_q.rdata <= sdp_pkg::RST_WORD;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// file: rtl/sdp_pkg.sv
`default_nettype none
package sdp_pkg;
  // ----------------------------------------------------------------
  // register map, byte addresses of 32-bit words
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WBUF0 = 8'h04;
  localparam logic [7:0] OFS_WBUF1 = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RBUF0 = 8'h10;
  localparam logic [7:0] OFS_RBUF3 = 8'h1C;
  // ----------------------------------------------------------------
  // control word fields
  // ----------------------------------------------------------------
  localparam int CTRL_WR_BIT = 7;
  localparam int IDX_WAKE_BIT = 5;
  localparam int IDX_CFG_BIT = 6;
  localparam int STAT_IGN_BIT = 8;
  localparam logic [4:0] RSV_ID_LO = 5'h1A;
  localparam logic [4:0] RSV_ID_HI = 5'h1E;
  localparam logic [7:0] NONWAKE_TYPE_BIT = 8'h10;
  // ----------------------------------------------------------------
  // reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [63:0] RST_CFG = 64'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// file: testbench/sdp_assertions.sv
`default_nettype none
module sdp_assertions #(parameter int ADDR_W = 8) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cw;
  logic rs;
  logic [6:0] idx_q;
  logic rsv_q;
  // ctrl word taken in one beat; split beats would leave idx_q stale
  // a beat without the low strobe carries no index, so it is not counted
  assign cw = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr == sdp_pkg::OFS_CTRL && s_axi_wstrb[0];
  assign rs = !s_axi_wdata[7] && (s_axi_wdata[4:0] == 5'h00
    || (s_axi_wdata[4:0] >= sdp_pkg::RSV_ID_LO && s_axi_wdata[4:0] <= sdp_pkg::RSV_ID_HI));
  // last index, and whether it fetched a reserved slot
  always_ff @(posedge aclk) idx_q <= !aresetn ? 7'h00 : cw ? s_axi_wdata[6:0] : idx_q;
  always_ff @(posedge aclk) rsv_q <= !aresetn ? 1'b0 : cw ? rs : rsv_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  AST_WR_LAT: assert property (cw |=> s_axi_bvalid)
    else $error("write answer late");
  AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  AST_NO_AR: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  AST_NO_AW: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("second write taken");
  AST_IDX: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == sdp_pkg::OFS_STATUS |=> s_axi_rdata[6:0] == idx_q)
    else $error("status index wrong");
  AST_RSV: assert property (s_axi_arvalid && s_axi_arready && rsv_q
    && s_axi_araddr == sdp_pkg::OFS_RBUF0 |=> s_axi_rdata == 32'h0000_0000)
    else $error("reserved slot not zero");
  COV_CW: cover property (cw);
  COV_RSV: cover property (rsv_q && s_axi_rvalid);
  COV_B: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind sdp_top sdp_assertions #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// file: testbench/sdp_host_model.sv
`default_nettype none
module sdp_host_model (
  input wire logic aclk,
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic awvalid,
  output logic wvalid,
  output logic arvalid,
  output logic rdy,
  input wire logic awready,
  input wire logic wready,
  input wire logic arready,
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // quiet bus from time zero
  initial
  begin
    {awvalid, wvalid, arvalid, rdy} = 4'h0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
  end
  // index as the host builds it: id, wakeup, configuration
  function automatic logic [7:0] idx(input logic c, input logic wk, input logic [4:0] id);
    return {1'b0, c, wk, id};
  endfunction
  // resolution step as the host derives it: range over two to the bit count,
  // kept with 16 fraction bits so that small steps do not vanish
  function automatic logic [31:0] res_step(input logic [31:0] w);
    return {w[15:0], 16'h0000} >> w[31:16];
  endfunction
  // one transfer; a shared ready stays high until the answer is seen
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic [1:0] r);
    logic ah;
    logic wh;
    ah = 1'b1;
    wh = w;
    @(posedge aclk);
    addr <= a;
    wdata <= wd;
    awvalid <= w;
    wvalid <= w;
    arvalid <= !w;
    rdy <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (ah && (w ? awready : arready)) ah = 1'b0;
      if (wh && wready) wh = 1'b0;
      awvalid <= w && ah;
      arvalid <= !w && ah;
      wvalid <= wh;
    end
    while (!(w ? bvalid : rvalid));
    rd = rdata;
    r = w ? bresp : rresp;
    rdy <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk;
  logic aresetn;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid, rdy;
  int mismatches;
  int check_count;
  // private fifo share, so the reserved quotient is not zero
  sdp_top #(.SHARED_FIFO(1'b0), .FIFO_RSV_BYTES(700)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(addr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(rdy),
    .s_axi_araddr(addr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rdy));
  sdp_host_model host (.aclk(aclk), .addr(addr), .wdata(wdata), .awvalid(awvalid),
    .wvalid(wvalid), .arvalid(arvalid), .rdy(rdy), .awready(awready), .wready(wready),
    .arready(arready), .bvalid(bvalid), .bresp(bresp), .rresp(rresp), .rvalid(rvalid),
    .rdata(rdata));
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic chk(input logic [7:0] a, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value reg %h expected %h seen %h", a, e, s);
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] v);
    host.xfer(1'b1, a, v, d, r);
  endtask
  task automatic ctl(input logic [7:0] v);
    put(sdp_pkg::OFS_CTRL, {24'h0, v});
  endtask
  task automatic see(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, d, r);
    chk(a, d, e);
  endtask
  task automatic finish_test;
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // the sequence needs well under two hundred cycles; this is far past it
  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    finish_test;
  end
  // slots, information words, refusals, then the unmapped word
  initial
  begin
    mismatches = 0;
    check_count = 0;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    see(sdp_pkg::OFS_STATUS, 32'h0);
    put(sdp_pkg::OFS_WBUF0, 32'h1122_3344);
    put(sdp_pkg::OFS_WBUF1, 32'h5566_7788);
    ctl(8'h80 | host.idx(1'b1, 1'b0, 5'h01));
    put(sdp_pkg::OFS_WBUF0, 32'hA5A5_0F0F);
    ctl(8'h80 | host.idx(1'b1, 1'b1, 5'h01));
    ctl(host.idx(1'b1, 1'b0, 5'h01));
    see(sdp_pkg::OFS_RBUF0, 32'h1122_3344);
    see(sdp_pkg::OFS_RBUF0 + 8'h04, 32'h5566_7788);
    see(sdp_pkg::OFS_RBUF0 + 8'h08, 32'h0);
    ctl(host.idx(1'b1, 1'b1, 5'h01));
    see(sdp_pkg::OFS_RBUF0, 32'hA5A5_0F0F);
    see(sdp_pkg::OFS_STATUS, 32'h61);
    ctl(host.idx(1'b0, 1'b0, 5'h01));
    see(sdp_pkg::OFS_RBUF0, 32'h0001_5A11);
    see(sdp_pkg::OFS_RBUF0 + 8'h04, 32'h000C_009D);
    chk(8'h14, host.res_step(d), 32'h0000_09D0);
    see(sdp_pkg::OFS_RBUF0 + 8'h08, 32'h0064_0000);
    see(sdp_pkg::OFS_RBUF3, 32'h0007_0124);
    chk(8'h1C, {30'h0, r}, {30'h0, sdp_pkg::RESP_OKAY});
    ctl(host.idx(1'b0, 1'b1, 5'h01));
    see(sdp_pkg::OFS_RBUF0, 32'h0001_5A21);
    ctl(host.idx(1'b0, 1'b0, 5'h05));
    for (int i = 0; i < 4; i++) see(sdp_pkg::OFS_RBUF0 + 8'(4 * i), 32'h0);
    ctl(8'h80 | host.idx(1'b1, 1'b0, 5'h1A));
    see(sdp_pkg::OFS_STATUS, 32'h15A);
    ctl(host.idx(1'b1, 1'b0, 5'h1A));
    see(sdp_pkg::OFS_RBUF0, 32'h0);
    ctl(8'h80 | host.idx(1'b0, 1'b0, 5'h01));
    see(sdp_pkg::OFS_STATUS, 32'h101);
    ctl(host.idx(1'b1, 1'b0, 5'h01));
    see(sdp_pkg::OFS_RBUF0, 32'h1122_3344);
    put(8'h40, 32'hFFFF_FFFF);
    chk(8'h40, {30'h0, r}, {30'h0, sdp_pkg::RESP_SLVERR});
    see(8'h40, 32'h0);
    chk(8'h40, {30'h0, r}, {30'h0, sdp_pkg::RESP_SLVERR});
    // second reset in mid-run: stored slot must come back cleared, status shows the newly written index
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    ctl(host.idx(1'b1, 1'b0, 5'h01));
    see(sdp_pkg::OFS_RBUF0, 32'h0);
    see(sdp_pkg::OFS_STATUS, 32'h41);
    finish_test;
  end
endmodule
`default_nettype wire
